/* rtl/usbpf_pkg.sv */
// Shared constants and types for the status pin function block
package usbpf_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_INT_STAT = 4'h2;
  localparam logic [3:0] OFS_INT_MASK = 4'h3;
  localparam logic [3:0] OFS_GPIO_DIR = 4'h4;
  localparam logic [3:0] OFS_GPIO_OUT = 4'h5;
  localparam logic [3:0] OFS_GPIO_IN = 4'h6;

  // Field positions
  localparam int unsigned CTRL_W = 5;
  localparam int unsigned EV_W = 4;
  localparam int unsigned EV_SUSPEND = 0;
  localparam int unsigned EV_RESUME = 1;
  localparam int unsigned EV_CONFIG = 2;
  localparam int unsigned EV_LOADED = 3;
  localparam int unsigned ST_SUSP = 0;
  localparam int unsigned ST_CFGD = 1;
  localparam int unsigned ST_LOADED = 2;
  localparam int unsigned ST_LAMP = 3;

  // Reset values; a direction bit of one means input
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [1:0] GPIO_DIR_RST = 2'h3;
  localparam logic [1:0] GPIO_OUT_RST = 2'h0;
  localparam logic [3:0] INT_MASK_RST = 4'h0;

  // Lamp timing
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_HALF_MS = 200;
  localparam int unsigned FAST_HALF_MS = 50;
  localparam int unsigned SLOW_HALF_CYC = CLK_HZ / 1000 * SLOW_HALF_MS;
  localparam int unsigned FAST_HALF_CYC = CLK_HZ / 1000 * FAST_HALF_MS;
  localparam logic [3:0] BLINK_HALVES = 4'h6;

  typedef enum logic [2:0] {
    LAMP_OFF = 3'h0,
    LAMP_ON = 3'h1,
    LAMP_TOGGLE = 3'h3,
    LAMP_SLOW = 3'h4,
    LAMP_FAST = 3'h5
  } usbpf_lamp_t;

  typedef enum logic {
    ST_LOAD,
    ST_RUN
  } usbpf_state_t;

  typedef struct packed {
    logic [2:0] lamp_mode;
    logic configured_indicator_select;
    logic suspend_indicator_select;
  } usbpf_cfg_t;

  typedef struct packed {
    logic o;
    logic oe;
  } usbpf_pin_t;

endpackage

/* rtl/usbpf_sync.sv */
// Two-stage synchroniser for pin inputs
module usbpf_sync #(
  parameter int unsigned W = 2
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  if (W < 1)
  begin : g_chk
    $error("usbpf_sync width must be at least one");
  end

  always_comb
  begin
    meta_nxt = d;
    q_nxt = meta_r;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      meta_r <= '0;
      q_r <= '0;
    end
    else
    begin
      meta_r <= meta_nxt;
      q_r <= q_nxt;
    end
  end

  assign q = q_r;
endmodule

/* rtl/usbpf_lamp.sv */
// Transmit activity lamp driver
module usbpf_lamp #(
  parameter int unsigned SLOW_HALF = usbpf_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = usbpf_pkg::FAST_HALF_CYC
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [2:0] mode,
  input wire logic tx_event,
  output logic lamp
);
  localparam int unsigned CW = $clog2(SLOW_HALF + 1);

  logic lamp_r;
  logic lamp_nxt;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic [3:0] left_r;
  logic [3:0] left_nxt;
  logic [CW-1:0] half;

  if (FAST_HALF < 1 || FAST_HALF > SLOW_HALF)
  begin : g_chk
    $error("usbpf_lamp needs 1 <= FAST_HALF <= SLOW_HALF");
  end

  assign half = (mode == usbpf_pkg::LAMP_FAST) ? CW'(FAST_HALF - 1) : CW'(SLOW_HALF - 1);

  // (R7) Lamp per stored mode
  always_comb
  begin
    lamp_nxt = lamp_r;
    cnt_nxt = cnt_r;
    left_nxt = left_r;
    // (R8) Mode code decode
    case (mode)
      usbpf_pkg::LAMP_ON:
      begin
        lamp_nxt = 1'b1;
        left_nxt = 4'h0;
      end
      usbpf_pkg::LAMP_TOGGLE:
      begin
        left_nxt = 4'h0;
        if (tx_event)
          lamp_nxt = ~lamp_r;
      end
      usbpf_pkg::LAMP_SLOW, usbpf_pkg::LAMP_FAST:
      begin
        // Activity starts a burst, or mid-burst reloads the halves left without resetting the phase; the burst always ends with the lamp dark
        if (left_r == 4'h0)
        begin
          if (tx_event)
          begin
            lamp_nxt = 1'b1;
            cnt_nxt = half;
            left_nxt = usbpf_pkg::BLINK_HALVES;
          end
        end
        else
        begin
          if (cnt_r == '0)
          begin
            cnt_nxt = half;
            left_nxt = left_r - 4'h1;
            lamp_nxt = (left_r == 4'h1) ? 1'b0 : ~lamp_r;
          end
          else
            cnt_nxt = cnt_r - CW'(1);
          if (tx_event)
            left_nxt = usbpf_pkg::BLINK_HALVES;
        end
      end
      default:
      begin
        // Off and every unassigned code keep the lamp dark
        lamp_nxt = 1'b0;
        left_nxt = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      lamp_r <= 1'b0;
      cnt_r <= '0;
      left_r <= 4'h0;
    end
    else
    begin
      lamp_r <= lamp_nxt;
      cnt_r <= cnt_nxt;
      left_r <= left_nxt;
    end
  end

  assign lamp = lamp_r;

  lamp_on_a: assert property (@(posedge clk) disable iff (!reset_n) // (R8)
    mode == usbpf_pkg::LAMP_ON |=> lamp_r)
    else $error("lamp dark in on mode");
  lamp_off_a: assert property (@(posedge clk) disable iff (!reset_n) // (R8)
    mode == 3'h0 |=> !lamp_r)
    else $error("lamp lit in off mode");
  lamp_toggle_a: assert property (@(posedge clk) disable iff (!reset_n) // (R7)
    mode == usbpf_pkg::LAMP_TOGGLE && tx_event |=> lamp_r != $past(lamp_r))
    else $error("lamp did not toggle on activity");
  blink_burst_c: cover property (@(posedge clk) disable iff (!reset_n)
    mode == usbpf_pkg::LAMP_FAST && tx_event && left_r == 4'h0);
endmodule

/* rtl/usbpf_top.sv */
// USB status pin functions: suspend and configured pins, activity lamp, registers
// Summary of operation
// (R1) Suspend pin selected: drive it low while the link is suspended.
// (R2) Suspend pin selected: drive it high while the link is resumed.
// (R3) Suspend select one routes the indication; zero leaves the pin as GPIO.
// (R4) Configured pin selected: held low from power-up or reset. The code leaves it undriven until the settings load.
// (R5) Configured pin goes high only after the host completes configuration.
// (R6) Configured select one routes the indication; zero leaves the pin as GPIO.
// (R7) Lamp mode kept in non-volatile storage; lamp follows the stored mode.
// (R8) Lamp codes: off 0, on 1, toggle 3, slow 4, fast 5.
// (R9) Settings load from non-volatile storage before enumeration is allowed.
module usbpf_top #(
  parameter int unsigned SLOW_HALF = usbpf_pkg::SLOW_HALF_CYC,
  parameter int unsigned FAST_HALF = usbpf_pkg::FAST_HALF_CYC
)(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [usbpf_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [usbpf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [usbpf_pkg::DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic nv_rd_req,
  input wire logic nv_rd_ack,
  input wire usbpf_pkg::usbpf_cfg_t nv_rd_data,
  output logic nv_wr_stb,
  output usbpf_pkg::usbpf_cfg_t nv_wr_data,
  input wire logic usb_suspend,
  input wire logic usb_configured,
  input wire logic tx_activity,
  output logic enum_enable,
  output usbpf_pkg::usbpf_pin_t suspend_status_pin,
  input wire logic suspend_status_pin_i,
  output usbpf_pkg::usbpf_pin_t configured_status_pin,
  input wire logic configured_status_pin_i,
  output logic transmit_activity_lamp
);
  usbpf_pkg::usbpf_state_t state_r;
  usbpf_pkg::usbpf_state_t state_nxt;
  usbpf_pkg::usbpf_cfg_t cfg_r;
  usbpf_pkg::usbpf_cfg_t cfg_nxt;
  logic nv_wr_r;
  logic nv_wr_nxt;
  usbpf_pkg::usbpf_cfg_t nv_wdat_r;
  usbpf_pkg::usbpf_cfg_t nv_wdat_nxt;

  logic [1:0] dir_r;
  logic [1:0] dir_nxt;
  logic [1:0] gout_r;
  logic [1:0] gout_nxt;
  logic [3:0] mask_r;
  logic [3:0] mask_nxt;
  logic [3:0] stat_r;
  logic [3:0] stat_nxt;
  logic irq_r;
  logic irq_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  logic susp_r;
  logic susp_nxt;
  logic cfgd_r;
  logic cfgd_nxt;
  logic [3:0] ev;

  usbpf_pkg::usbpf_pin_t sp_r;
  usbpf_pkg::usbpf_pin_t sp_nxt;
  usbpf_pkg::usbpf_pin_t cp_r;
  usbpf_pkg::usbpf_pin_t cp_nxt;

  logic [1:0] pin_in;
  logic lamp;
  logic running;

  function automatic logic hit(
    input logic [usbpf_pkg::ADDR_W-1:0] a,
    input logic [3:0] ofs
  );
    hit = (a == ofs);
  endfunction

  usbpf_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .d({configured_status_pin_i, suspend_status_pin_i}),
    .q(pin_in)
  );

  usbpf_lamp #(
    .SLOW_HALF(SLOW_HALF),
    .FAST_HALF(FAST_HALF)
  ) u_lamp (
    .clk(clk),
    .reset_n(reset_n),
    .mode(cfg_r.lamp_mode),
    .tx_event(tx_activity),
    .lamp(lamp)
  );

  assign running = (state_r == usbpf_pkg::ST_RUN);

  // (R9) Load settings first
  always_comb
  begin
    state_nxt = state_r;
    cfg_nxt = cfg_r;
    nv_wr_nxt = 1'b0;
    nv_wdat_nxt = nv_wdat_r;
    case (state_r)
      usbpf_pkg::ST_LOAD:
      begin
        if (nv_rd_ack)
        begin
          cfg_nxt = nv_rd_data;
          state_nxt = usbpf_pkg::ST_RUN;
        end
      end
      usbpf_pkg::ST_RUN:
      begin
        // (R7) Mode written to storage
        if (reg_wr && hit(reg_addr, usbpf_pkg::OFS_CTRL))
        begin
          cfg_nxt = usbpf_pkg::usbpf_cfg_t'(reg_wdata[usbpf_pkg::CTRL_W-1:0]);
          nv_wr_nxt = 1'b1;
          nv_wdat_nxt = usbpf_pkg::usbpf_cfg_t'(reg_wdata[usbpf_pkg::CTRL_W-1:0]);
        end
      end
      default:
      begin
        state_nxt = usbpf_pkg::ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      state_r <= usbpf_pkg::ST_LOAD;
      cfg_r <= usbpf_pkg::CTRL_RST;
      nv_wr_r <= 1'b0;
      nv_wdat_r <= usbpf_pkg::CTRL_RST;
    end
    else
    begin
      state_r <= state_nxt;
      cfg_r <= cfg_nxt;
      nv_wr_r <= nv_wr_nxt;
      nv_wdat_r <= nv_wdat_nxt;
    end
  end

  // Link state and events; configured is only believed once settings are in
  always_comb
  begin
    susp_nxt = usb_suspend;
    cfgd_nxt = usb_configured && running;
    ev = '0;
    ev[usbpf_pkg::EV_SUSPEND] = usb_suspend && !susp_r;
    ev[usbpf_pkg::EV_RESUME] = !usb_suspend && susp_r;
    ev[usbpf_pkg::EV_CONFIG] = cfgd_nxt && !cfgd_r;
    ev[usbpf_pkg::EV_LOADED] = !running && nv_rd_ack;
  end

  // Software registers; an event in the clearing cycle stays set
  always_comb
  begin
    dir_nxt = dir_r;
    gout_nxt = gout_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (reg_wr && hit(reg_addr, usbpf_pkg::OFS_GPIO_DIR))
      dir_nxt = reg_wdata[1:0];
    if (reg_wr && hit(reg_addr, usbpf_pkg::OFS_GPIO_OUT))
      gout_nxt = reg_wdata[1:0];
    if (reg_wr && hit(reg_addr, usbpf_pkg::OFS_INT_MASK))
      mask_nxt = reg_wdata[3:0];
    if (reg_wr && hit(reg_addr, usbpf_pkg::OFS_INT_STAT))
      stat_nxt = stat_r & ~reg_wdata[3:0];
    stat_nxt = stat_nxt | ev;
    irq_nxt = |(stat_nxt & mask_nxt);
    rdata_nxt = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        usbpf_pkg::OFS_CTRL: rdata_nxt = {3'h0, cfg_r};
        usbpf_pkg::OFS_STATUS:
        begin
          rdata_nxt[usbpf_pkg::ST_SUSP] = susp_r;
          rdata_nxt[usbpf_pkg::ST_CFGD] = cfgd_r;
          rdata_nxt[usbpf_pkg::ST_LOADED] = running;
          rdata_nxt[usbpf_pkg::ST_LAMP] = lamp;
        end
        usbpf_pkg::OFS_INT_STAT: rdata_nxt = {4'h0, stat_r};
        usbpf_pkg::OFS_INT_MASK: rdata_nxt = {4'h0, mask_r};
        usbpf_pkg::OFS_GPIO_DIR: rdata_nxt = {6'h00, dir_r};
        usbpf_pkg::OFS_GPIO_OUT: rdata_nxt = {6'h00, gout_r};
        usbpf_pkg::OFS_GPIO_IN: rdata_nxt = {6'h00, pin_in};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dir_r <= usbpf_pkg::GPIO_DIR_RST;
      gout_r <= usbpf_pkg::GPIO_OUT_RST;
      mask_r <= usbpf_pkg::INT_MASK_RST;
      stat_r <= 4'h0;
      irq_r <= 1'b0;
      rdata_r <= 8'h00;
      susp_r <= 1'b0;
      cfgd_r <= 1'b0;
    end
    else
    begin
      dir_r <= dir_nxt;
      gout_r <= gout_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
      susp_r <= susp_nxt;
      cfgd_r <= cfgd_nxt;
    end
  end

  // Pin functions
  always_comb
  begin
    // (R3) Suspend pin routing
    if (cfg_r.suspend_indicator_select)
    begin
      sp_nxt.oe = 1'b1;
      // (R1) (R2) Low when suspended
      sp_nxt.o = !usb_suspend;
    end
    else
    begin
      sp_nxt.oe = !dir_r[0];
      sp_nxt.o = gout_r[0];
    end
    // (R6) Configured pin routing
    if (cfg_r.configured_indicator_select)
    begin
      cp_nxt.oe = 1'b1;
      // (R5) High once configured
      cp_nxt.o = cfgd_nxt;
    end
    else
    begin
      cp_nxt.oe = !dir_r[1];
      cp_nxt.o = gout_r[1];
    end
  end

  always_ff @(posedge clk)
  begin
    // (R4) Both pins undriven out of reset, output bits low
    if (!reset_n)
    begin
      sp_r <= '0;
      cp_r <= '0;
    end
    else
    begin
      sp_r <= sp_nxt;
      cp_r <= cp_nxt;
    end
  end

  assign suspend_status_pin = sp_r;
  assign configured_status_pin = cp_r;
  assign transmit_activity_lamp = lamp;
  assign nv_rd_req = !running;
  assign nv_wr_stb = nv_wr_r;
  assign nv_wr_data = nv_wdat_r;
  assign enum_enable = running;
  assign irq = irq_r;
  assign reg_rdata = rdata_r;

  susp_low_a: assert property (@(posedge clk) disable iff (!reset_n) // (R1)
    cfg_r.suspend_indicator_select && usb_suspend |=> sp_r.oe && !sp_r.o)
    else $error("suspend pin not low in suspend");
  susp_high_a: assert property (@(posedge clk) disable iff (!reset_n) // (R2)
    cfg_r.suspend_indicator_select && !usb_suspend |=> sp_r.oe && sp_r.o)
    else $error("suspend pin not high when resumed");
  susp_gpio_a: assert property (@(posedge clk) disable iff (!reset_n) // (R3)
    !cfg_r.suspend_indicator_select |=> sp_r.oe == !$past(dir_r[0]) && sp_r.o == $past(gout_r[0]))
    else $error("suspend pin not released to GPIO");
  cfg_reset_a: assert property (@(posedge clk) // (R4)
    !reset_n |=> !cp_r.o && !cfgd_r)
    else $error("configured pin not low after reset");
  cfg_high_a: assert property (@(posedge clk) disable iff (!reset_n) // (R5)
    cfg_r.configured_indicator_select |=> cp_r.o == ($past(usb_configured) && $past(running)))
    else $error("configured pin does not follow configuration");
  cfg_gpio_a: assert property (@(posedge clk) disable iff (!reset_n) // (R6)
    !cfg_r.configured_indicator_select |=> cp_r.oe == !$past(dir_r[1]))
    else $error("configured pin not released to GPIO");
  nv_store_a: assert property (@(posedge clk) disable iff (!reset_n) // (R7)
    running && reg_wr && reg_addr == usbpf_pkg::OFS_CTRL |=> nv_wr_r && nv_wdat_r == cfg_r)
    else $error("control write not stored");
  load_first_a: assert property (@(posedge clk) disable iff (!reset_n) // (R9)
    !running && nv_rd_ack |=> enum_enable && cfg_r == $past(nv_rd_data))
    else $error("settings not applied before enumeration");
  w1c_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    usb_suspend && !susp_r |=> stat_r[usbpf_pkg::EV_SUSPEND])
    else $error("suspend event lost");

  suspend_resume_c: cover property (@(posedge clk) disable iff (!reset_n)
    cfg_r.suspend_indicator_select && usb_suspend ##[1:20] !usb_suspend);
  configured_c: cover property (@(posedge clk) disable iff (!reset_n)
    cfg_r.configured_indicator_select && $rose(cfgd_r));
  irq_c: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq_r));
endmodule

/* verification/usbpf_host_model.sv */
// Behavioural USB host that suspends, resumes and configures the device
module usbpf_host_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic enum_enable,
  input wire logic want_suspend,
  input wire logic want_config,
  input wire logic slow,
  output logic usb_suspend,
  output logic usb_configured
);
  timeunit 1ns;
  timeprecision 1ps;
  logic susp_d;
  logic cfg_d;

  // Slow mode answers one cycle late, as a lazy host would
  always @(posedge clk)
  begin
    if (!reset_n)
    begin
      susp_d <= 1'b0;
      cfg_d <= 1'b0;
      usb_suspend <= 1'b0;
      usb_configured <= 1'b0;
    end
    else
    begin
      susp_d <= want_suspend;
      cfg_d <= want_config && enum_enable;
      usb_suspend <= slow ? susp_d : want_suspend;
      usb_configured <= slow ? cfg_d : (want_config && enum_enable);
    end
  end
endmodule

/* verification/usbpf_top_bench.sv */
// Self-checking bench for the status pin function block
module usbpf_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic nv_rd_ack = 1'b0;
  logic tx_activity = 1'b0;
  logic want_susp = 1'b0;
  logic want_cfg = 1'b0;
  logic slow = 1'b0;
  logic look = 1'b0;
  logic loaded = 1'b0;
  logic rd_q = 1'b0;
  logic [1:0] ext = 2'h0;
  logic [1:0] rnd = 2'h0;
  logic [4:0] wmask = 5'h00;
  logic [4:0] w_exp = 5'h00;
  logic [7:0] reg_rdata;
  logic irq;
  logic nv_rd_req;
  logic nv_wr_stb;
  logic enum_enable;
  logic lamp;
  logic usb_suspend;
  logic usb_configured;
  logic [15:0] got;
  logic [15:0] exp_v;
  logic [15:0] notes[$];
  logic [2:0] codes[4] = '{3'h0, 3'h1, 3'h2, 3'h7};
  usbpf_pkg::usbpf_cfg_t nv_rd_data = 5'h00;
  usbpf_pkg::usbpf_cfg_t nv_wr_data;
  usbpf_pkg::usbpf_pin_t sp;
  usbpf_pkg::usbpf_pin_t cp;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  // Pin level as seen on the wire: the driver wins over the outside world
  wire sp_i = sp.oe ? sp.o : ext[0];
  wire cp_i = cp.oe ? cp.o : ext[1];

  usbpf_top #(.SLOW_HALF(8), .FAST_HALF(3)) dut_u (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .nv_rd_req(nv_rd_req), .nv_rd_ack(nv_rd_ack), .nv_rd_data(nv_rd_data),
    .nv_wr_stb(nv_wr_stb), .nv_wr_data(nv_wr_data), .usb_suspend(usb_suspend),
    .usb_configured(usb_configured), .tx_activity(tx_activity),
    .enum_enable(enum_enable), .suspend_status_pin(sp), .suspend_status_pin_i(sp_i),
    .configured_status_pin(cp), .configured_status_pin_i(cp_i),
    .transmit_activity_lamp(lamp)
  );

  usbpf_host_model host_u (
    .clk(clk), .reset_n(reset_n), .enum_enable(enum_enable), .want_suspend(want_susp),
    .want_config(want_cfg), .slow(slow), .usb_suspend(usb_suspend),
    .usb_configured(usb_configured)
  );

  always #10 clk = ~clk;

  always @(posedge clk)
  begin
    rd_q <= reg_rd;
    if (rd_q || look || nv_wr_stb)
    begin
      exp_v = notes.pop_front();
      if (nv_wr_stb)
        got = {8'h01, 3'h0, nv_wr_data};
      else if (rd_q)
        got = {8'h00, reg_rdata};
      else
        got = {3'h0, nv_wr_data & wmask, nv_rd_req, enum_enable, irq, sp, cp, lamp};
      compares++;
      if (got !== exp_v)
      begin
        failures++;
        $display("BAD t=%0t got %h exp %h", $time, got, exp_v);
      end
    end
  end

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      close_out();
    end
  end

  task close_out;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    // A control write once settings are in must also reach storage
    if (a == usbpf_pkg::OFS_CTRL && loaded)
      notes.push_back({8'h01, 3'h0, d[4:0]});
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e);
    notes.push_back({8'h00, e});
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask

  // Order of fields: load pending, enumerate, irq, pins {o, oe}, lamp
  task chk(input logic [7:0] r);
    notes.push_back({3'h0, w_exp, r});
    @(posedge clk);
    look <= 1'b1;
    @(posedge clk);
    look <= 1'b0;
  endtask

  task send_tx;
    @(posedge clk);
    tx_activity <= 1'b1;
    @(posedge clk);
    tx_activity <= 1'b0;
  endtask

  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  task done(input string s);
    $display("test %s done", s);
  endtask

  initial
  begin
    void'($urandom(32'hEA25));
    ext = 2'($urandom);
    rnd = 2'($urandom);
    slow = 1'($urandom);
    idle(20);
    reset_n <= 1'b1;
    chk(8'h80);
    wr(usbpf_pkg::OFS_CTRL, 8'h03);
    rd(usbpf_pkg::OFS_CTRL, 8'h00);
    rd(usbpf_pkg::OFS_GPIO_DIR, 8'h03);
    rd(usbpf_pkg::OFS_INT_MASK, 8'h00);
    rd(4'hF, 8'h00);
    rd(usbpf_pkg::OFS_GPIO_IN, {6'h00, ext});
    done("reset");
    nv_rd_data <= 5'h0F;
    nv_rd_ack <= 1'b1;
    loaded = 1'b1;
    @(posedge clk);
    nv_rd_ack <= 1'b0;
    idle(3);
    chk(8'h5A);
    rd(usbpf_pkg::OFS_INT_STAT, 8'h08);
    done("load");
    wr(usbpf_pkg::OFS_INT_MASK, 8'h01);
    want_susp <= 1'b1;
    idle(4);
    chk(8'h6A);
    rd(usbpf_pkg::OFS_STATUS, 8'h05);
    wr(usbpf_pkg::OFS_INT_STAT, 8'h0F);
    want_susp <= 1'b0;
    idle(4);
    chk(8'h5A);
    rd(usbpf_pkg::OFS_INT_STAT, 8'h02);
    done("suspend");
    want_cfg <= 1'b1;
    idle(4);
    chk(8'h5E);
    send_tx();
    chk(8'h5F);
    send_tx();
    chk(8'h5E);
    done("configure");
    wmask = 5'h1F;
    for (int i = 0; i < 4; i++)
    begin
      w_exp = {codes[i], 2'h3};
      wr(usbpf_pkg::OFS_CTRL, {3'h0, w_exp});
      chk({7'h2F, codes[i] == 3'h1});
    end
    for (int i = 0; i < 2; i++)
    begin
      w_exp = {3'(4 + i), 2'h3};
      wr(usbpf_pkg::OFS_CTRL, {3'h0, w_exp});
      send_tx();
      chk(8'h5F);
      // Second lit half of the burst
      idle(i == 0 ? 15 : 4);
      chk(8'h5F);
      idle(i == 0 ? 60 : 25);
      chk(8'h5E);
    end
    done("lamp");
    w_exp = 5'h00;
    wr(usbpf_pkg::OFS_CTRL, 8'h00);
    wr(usbpf_pkg::OFS_GPIO_DIR, 8'h00);
    wr(usbpf_pkg::OFS_GPIO_OUT, {6'h00, rnd});
    idle(2);
    chk({3'h2, rnd[0], 1'b1, rnd[1], 2'h2});
    rd(usbpf_pkg::OFS_GPIO_IN, {6'h00, rnd});
    wr(usbpf_pkg::OFS_GPIO_DIR, 8'h03);
    idle(3);
    rd(usbpf_pkg::OFS_GPIO_IN, {6'h00, ext});
    done("gpio");
    // Reset in mid-run: the configured pin is undriven again until the settings reload
    reset_n <= 1'b0;
    loaded = 1'b0;
    idle(3);
    reset_n <= 1'b1;
    chk(8'h80);
    nv_rd_ack <= 1'b1;
    loaded = 1'b1;
    @(posedge clk);
    nv_rd_ack <= 1'b0;
    chk(8'h5A);
    idle(4);
    chk(8'h5E);
    done("rerun");
    idle(3);
    close_out();
  end
endmodule
